/* File: verilog/chp_map.vh */
/*
 Constants for the codec host register port: direct and indirect offsets,
 field positions, reset values and timing counts. Definitions only.
*/
`ifndef CHP_MAP_VH
`define CHP_MAP_VH
// Direct locations on direct_select
`define CHP_DIR_INDEX 2'h0
`define CHP_DIR_WINDOW 2'h1
`define CHP_DIR_STATUS 2'h2
`define CHP_DIR_PIO 2'h3
// Indirect register indices
`define CHP_IX_LOUT 4'h6
`define CHP_IX_ROUT 4'h7
`define CHP_IX_FORMAT 4'h8
`define CHP_IX_IFCFG 4'h9
`define CHP_IX_PINS 4'ha
`define CHP_IX_TEST 4'hb
`define CHP_IX_MISC 4'hc
`define CHP_IX_BASE_HI 4'he
`define CHP_IX_BASE_LO 4'hf
// Index address fields
`define CHP_IDX_INIT 7
`define CHP_IDX_PERMIT 6
`define CHP_IDX_HOLD 5
// Format fields
`define CHP_FMT_FMT 6
`define CHP_FMT_CL 5
`define CHP_FMT_SM 4
`define CHP_FMT_CSS 0
// Interface configuration fields
`define CHP_CFG_CPIO 7
`define CHP_CFG_PPIO 6
`define CHP_CFG_CEN 1
`define CHP_CFG_PEN 0
`define CHP_CFG_ON_MASK 8'h03
// Other fields
`define CHP_PIN_IEN 1
`define CHP_OUT_MUTE 7
// Reset and fixed values
`define CHP_INDEX_RESET 8'h40
`define CHP_INIT_READ 8'h80
`define CHP_MIDSCALE8 8'h80
// Timing
`define CHP_SETTLE_SAMPLES 8'd128
`define CHP_INIT_CYCLES 16'd1024
// Crystal divide ratios per rate select
`define CHP_DIV0 12'd3072
`define CHP_DIV1 12'd1536
`define CHP_DIV2 12'd896
`define CHP_DIV3 12'd768
`define CHP_DIV4 12'd448
`define CHP_DIV5 12'd384
`define CHP_DIV6 12'd512
`define CHP_DIV7 12'd2560
`endif

/* File: verilog/chp_reg_ram.v */
/*
 Sixteen by eight indirect register store with registered read.
 Assumes the caller resolves write permission before writing.
*/
`timescale 1ns/1ps
`default_nettype none
module chp_reg_ram (
   // Clock
   input wire sys_clk,
   // Write port
   input wire wr_en,
   input wire [3:0] wr_addr,
   input wire [7:0] wr_data,
   // Read port
   input wire [3:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:15];

   always @(posedge sys_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule // chp_reg_ram
`default_nettype wire

/* File: verilog/chp_rate_div.v */
/*
 Sample rate divider: picks one of two crystal tick streams and divides it.
 Assumes crystal ticks are one-cycle pulses synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "chp_map.vh"
module chp_rate_div (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Crystal ticks
   input wire xtal_a_tick,
   input wire xtal_b_tick,
   // Selection
   input wire crystal_select,
   input wire [2:0] rate_divider_select,
   // Sample period pulse
   output reg sample_tick
);
   reg [11:0] count_reg;
   reg [11:0] ratio;
   wire tick = crystal_select ? xtal_b_tick : xtal_a_tick;

   always @* begin
      case (rate_divider_select)
         3'd0: ratio = `CHP_DIV0;
         3'd1: ratio = `CHP_DIV1;
         3'd2: ratio = `CHP_DIV2;
         3'd3: ratio = `CHP_DIV3;
         3'd4: ratio = `CHP_DIV4;
         3'd5: ratio = `CHP_DIV5;
         3'd6: ratio = `CHP_DIV6;
         default: ratio = `CHP_DIV7;
      endcase
   end

   always @(posedge sys_clk) begin
      if (sys_rst) begin
         count_reg <= 12'h000;
         sample_tick <= 1'b0;
      end else begin
         sample_tick <= 1'b0;
         if (tick) begin
            if (count_reg >= ratio - 12'd1) begin
               count_reg <= 12'h000;
               sample_tick <= 1'b1;
            end else begin
               count_reg <= count_reg + 12'd1;
            end
         end
      end
   end
endmodule // chp_rate_div
`default_nettype wire

/* File: verilog/chp_host_port.v */
/*
 Byte-wide host register port of a stereo codec: direct locations, indirect
 window, status, PIO data, DMA count, interrupt flag and mode-change settle.
 Assumes host strobes are one-cycle pulses synchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "chp_map.vh"
// Overview of operation
// - Two address bits pick four direct registers
// - Window reaches register chosen by last index
// - Low four index bits select indirect register
// - Fixed sixteen-entry indirect register map
// - Only interrupt flag sticky, rest refreshed
// - Status write clears interrupt flag, unless underflow sets it that cycle
// - Only count underflow sets interrupt flag
// - Interrupt pin follows flag when gate set
// - Hold clear: requests and counting run freely
// - Hold with flag: no new requests, midscale
// - Counter frozen while hold and flag set
// - Format and config writes need reconfig permit, except the config enable bits
// - DACs muted while reconfig permit set
// - Converters muted 128 samples after permit exit
// - Calibration active high during settle interval
// - Init flag read-only, set while busy
// - Index reads 80h during init, 40h after
// - Window ignores writes, reads 80h in init
// - Playback slot free flag in status
// - Playback side flag: zero means right
// - Playback half flag: zero means lower
// - Two crystal inputs with select mux
// - Crystal divided to eight sample rates
module chp_host_port #(
   parameter [15:0] INIT_CYCLES = `CHP_INIT_CYCLES,
   parameter [3:0] CHIP_REV = 4'h5 // Arbitrary value
) (
   // Clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // Host bus
   input wire [1:0] direct_select,
   input wire host_rd,
   input wire host_wr,
   input wire [7:0] host_din,
   output reg [7:0] host_dout,
   output reg host_dout_oe,
   // DMA
   input wire playback_dma_ack,
   input wire capture_dma_ack,
   output reg playback_dma_req,
   output reg capture_dma_req,
   output reg irq_out,
   // Crystals
   input wire xtal_a_tick,
   input wire xtal_b_tick,
   // Converters
   input wire [15:0] adc_left,
   input wire [15:0] adc_right,
   output reg [15:0] dac_left,
   output reg [15:0] dac_right,
   output reg dac_left_mute,
   output reg dac_right_mute,
   output reg adc_mute
);
   reg [15:0] init_cnt_reg;
   reg init_busy_reg;
   reg reconfig_permit_reg;
   reg request_hold_on_irq_reg;
   reg [3:0] indirect_pointer_reg;
   reg [7:0] lout_reg, rout_reg, format_reg, ifcfg_reg, pins_reg;
   reg [7:0] base_hi_reg, base_lo_reg;
   reg irq_reg;
   reg [15:0] count_reg;
   reg [7:0] settle_reg;
   reg [2:0] pb_idx_reg, cap_idx_reg;
   reg [15:0] pb_l_reg, pb_r_reg, cap_l_reg, cap_r_reg;
   reg cap_fresh_reg, pur_reg, cor_reg;
   reg [7:0] rd_next, ram_wdata, cap_byte;
   wire [7:0] ram_rdata;
   wire sample_tick;
   wire [7:0] index_reset = `CHP_INDEX_RESET;

   // Host access decode
   wire pio_wr = host_wr & (playback_dma_ack | direct_select == `CHP_DIR_PIO);
   wire pio_rd = host_rd & (capture_dma_ack | direct_select == `CHP_DIR_PIO);
   wire dir_wr = host_wr & ~playback_dma_ack & ~init_busy_reg;
   wire idx_wr = dir_wr & direct_select == `CHP_DIR_INDEX;
   wire win_wr = dir_wr & direct_select == `CHP_DIR_WINDOW;
   wire sts_wr = host_wr & ~playback_dma_ack & direct_select == `CHP_DIR_STATUS;

   // Format decode
   wire sixteen = format_reg[`CHP_FMT_FMT] & ~format_reg[`CHP_FMT_CL];
   wire stereo = format_reg[`CHP_FMT_SM];
   wire [2:0] byte_count = {stereo & sixteen, stereo ^ sixteen, ~(stereo | sixteen)};
   wire pb_on = ifcfg_reg[`CHP_CFG_PEN];
   wire cap_on = ifcfg_reg[`CHP_CFG_CEN];
   wire hold = request_hold_on_irq_reg & irq_reg;
   wire settling = settle_reg != 8'd0;
   wire pb_full = pb_idx_reg == byte_count;
   wire cap_last = cap_idx_reg + 3'd1 >= byte_count;

   // Byte position for playback and capture sequencing
   wire pb_right = sixteen ? pb_idx_reg[1] : pb_idx_reg[0];
   wire pb_upper = sixteen ? pb_idx_reg[0] : 1'b1;
   wire cap_right = sixteen ? cap_idx_reg[1] : cap_idx_reg[0];
   wire cap_upper = sixteen ? cap_idx_reg[0] : 1'b1;

   // Status image rebuilt every cycle from live state
   wire [7:0] status = {cap_upper, ~cap_right, cap_fresh_reg, pur_reg | cor_reg,
                        pb_upper, ~pb_right, ~pb_full, irq_reg};

   chp_reg_ram u_ram (
      .sys_clk(sys_clk),
      .wr_en(win_wr),
      .wr_addr(indirect_pointer_reg),
      .wr_data(ram_wdata),
      .rd_addr(indirect_pointer_reg),
      .rd_data(ram_rdata)
   );

   chp_rate_div u_div (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .xtal_a_tick(xtal_a_tick),
      .xtal_b_tick(xtal_b_tick),
      .crystal_select(format_reg[`CHP_FMT_CSS]),
      .rate_divider_select(format_reg[3:1]),
      .sample_tick(sample_tick)
   );

   // Write merge: format and config locked unless permit set, except config enable bits
   always @* begin
      ram_wdata = host_din;
      if (!reconfig_permit_reg) begin
         if (indirect_pointer_reg == `CHP_IX_FORMAT) begin
            ram_wdata = format_reg;
         end else if (indirect_pointer_reg == `CHP_IX_IFCFG) begin
            ram_wdata = (ifcfg_reg & ~`CHP_CFG_ON_MASK) | (host_din & `CHP_CFG_ON_MASK);
         end
      end
   end

   // Capture byte select; 8-bit data is unsigned
   always @* begin
      cap_byte = cap_right ? (cap_upper ? cap_r_reg[15:8] : cap_r_reg[7:0])
                           : (cap_upper ? cap_l_reg[15:8] : cap_l_reg[7:0]);
      if (!sixteen) begin
         cap_byte = cap_byte ^ `CHP_MIDSCALE8;
      end
   end

   // Read data mux
   always @* begin
      case (direct_select)
         `CHP_DIR_INDEX: rd_next = {init_busy_reg, reconfig_permit_reg, request_hold_on_irq_reg,
                                    1'b0, indirect_pointer_reg};
         `CHP_DIR_WINDOW: begin
            case (indirect_pointer_reg)
               `CHP_IX_TEST: rd_next = {cor_reg, pur_reg, settling, 5'h00};
               `CHP_IX_MISC: rd_next = {4'h0, CHIP_REV};
               default: rd_next = ram_rdata;
            endcase
         end
         `CHP_DIR_STATUS: rd_next = status;
         default: rd_next = cap_byte;
      endcase
      if (init_busy_reg && direct_select != `CHP_DIR_STATUS) begin
         rd_next = `CHP_INIT_READ;
      end
      if (capture_dma_ack) begin
         rd_next = init_busy_reg ? `CHP_INIT_READ : cap_byte;
      end
   end

   // Initialization lockout after reset
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         init_cnt_reg <= 16'h0000;
         init_busy_reg <= 1'b1;
      end else if (init_busy_reg) begin
         init_cnt_reg <= init_cnt_reg + 16'd1;
         if (init_cnt_reg >= INIT_CYCLES - 16'd1) begin
            init_busy_reg <= 1'b0;
         end
      end
   end

   // Direct and shadowed indirect control registers
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         reconfig_permit_reg <= index_reset[`CHP_IDX_PERMIT];
         request_hold_on_irq_reg <= index_reset[`CHP_IDX_HOLD];
         indirect_pointer_reg <= 4'h0;
         lout_reg <= 8'h00;
         rout_reg <= 8'h00;
         format_reg <= 8'h00;
         ifcfg_reg <= 8'h00;
         pins_reg <= 8'h00;
         base_hi_reg <= 8'h00;
         base_lo_reg <= 8'h00;
      end else begin
         if (idx_wr) begin
            reconfig_permit_reg <= host_din[`CHP_IDX_PERMIT];
            request_hold_on_irq_reg <= host_din[`CHP_IDX_HOLD];
            indirect_pointer_reg <= host_din[3:0];
         end
         if (win_wr) begin
            case (indirect_pointer_reg)
               `CHP_IX_LOUT: lout_reg <= host_din;
               `CHP_IX_ROUT: rout_reg <= host_din;
               `CHP_IX_FORMAT: format_reg <= ram_wdata;
               `CHP_IX_IFCFG: ifcfg_reg <= ram_wdata;
               `CHP_IX_PINS: pins_reg <= host_din;
               `CHP_IX_BASE_HI: base_hi_reg <= host_din;
               `CHP_IX_BASE_LO: base_lo_reg <= host_din;
               default: ;
            endcase
         end
      end
   end

   // Interrupt flag, DMA count and settle timer
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         irq_reg <= 1'b0;
         count_reg <= 16'h0000;
         settle_reg <= 8'd0;
      end else begin
         if (win_wr && indirect_pointer_reg == `CHP_IX_BASE_LO) begin
            count_reg <= {base_hi_reg, host_din};
         end else if (sample_tick && (pb_on || cap_on) && !hold) begin
            if (count_reg == 16'h0000) begin
               count_reg <= {base_hi_reg, base_lo_reg};
            end else begin
               count_reg <= count_reg - 16'd1;
            end
         end
         // Underflow is the only source; set beats a same-cycle clear
         if (sample_tick && (pb_on || cap_on) && !hold && count_reg == 16'h0000) begin
            irq_reg <= 1'b1;
         end else if (sts_wr) begin
            irq_reg <= 1'b0;
         end
         if (idx_wr && reconfig_permit_reg && !host_din[`CHP_IDX_PERMIT]) begin
            settle_reg <= `CHP_SETTLE_SAMPLES;
         end else if (sample_tick && settling) begin
            settle_reg <= settle_reg - 8'd1;
         end
      end
   end

   // Playback byte sequencing and DAC feed
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         pb_idx_reg <= 3'd0;
         pb_l_reg <= 16'h0000;
         pb_r_reg <= 16'h0000;
         pur_reg <= 1'b0;
         dac_left <= 16'h0000;
         dac_right <= 16'h0000;
         playback_dma_req <= 1'b0;
      end else begin
         // Bytes past a full sample are dropped, not queued
         if (pio_wr && !init_busy_reg && !pb_full) begin
            pb_idx_reg <= pb_idx_reg + 3'd1;
            if (pb_idx_reg + 3'd1 == byte_count) begin
               playback_dma_req <= 1'b0;
            end
            if (pb_right) begin
               if (pb_upper) pb_r_reg[15:8] <= host_din;
               else pb_r_reg[7:0] <= host_din;
            end else begin
               if (pb_upper) pb_l_reg[15:8] <= host_din;
               else pb_l_reg[7:0] <= host_din;
            end
         end
         if (sample_tick) begin
            pb_idx_reg <= 3'd0;
            pur_reg <= pb_on & ~pb_full;
            if (!pb_on || hold || !pb_full) begin
               dac_left <= 16'h0000;
               dac_right <= 16'h0000;
            end else if (sixteen) begin
               dac_left <= pb_l_reg;
               dac_right <= stereo ? pb_r_reg : pb_l_reg;
            end else begin
               dac_left <= {pb_l_reg[15:8] ^ `CHP_MIDSCALE8, 8'h00};
               dac_right <= {(stereo ? pb_r_reg[15:8] : pb_l_reg[15:8]) ^ `CHP_MIDSCALE8, 8'h00};
            end
            // A pending request survives the hold until served
            if (!hold || !pb_on) begin
               playback_dma_req <= pb_on & ~ifcfg_reg[`CHP_CFG_PPIO] & ~hold;
            end
         end
      end
   end

   // Capture sampling and byte sequencing
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         cap_idx_reg <= 3'd0;
         cap_l_reg <= 16'h0000;
         cap_r_reg <= 16'h0000;
         cap_fresh_reg <= 1'b0;
         cor_reg <= 1'b0;
         capture_dma_req <= 1'b0;
      end else begin
         if (pio_rd && !init_busy_reg && cap_fresh_reg) begin
            if (cap_last) begin
               cap_fresh_reg <= 1'b0;
               capture_dma_req <= 1'b0;
            end else begin
               cap_idx_reg <= cap_idx_reg + 3'd1;
            end
         end
         // Under hold the buffer keeps its last sample
         if (sample_tick && cap_on && !hold) begin
            cap_idx_reg <= 3'd0;
            cap_fresh_reg <= 1'b1;
            cor_reg <= cap_fresh_reg;
            cap_l_reg <= settling ? 16'h0000 : adc_left;
            cap_r_reg <= settling ? 16'h0000 : (stereo ? adc_right : adc_left);
            capture_dma_req <= ~ifcfg_reg[`CHP_CFG_CPIO];
         end
      end
   end

   // Host read answer and pin outputs
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         host_dout <= 8'h00;
         host_dout_oe <= 1'b0;
         irq_out <= 1'b0;
         dac_left_mute <= 1'b1;
         dac_right_mute <= 1'b1;
         adc_mute <= 1'b1;
      end else begin
         host_dout_oe <= host_rd;
         if (host_rd) begin
            host_dout <= rd_next;
         end
         irq_out <= irq_reg & pins_reg[`CHP_PIN_IEN];
         dac_left_mute <= reconfig_permit_reg | settling | lout_reg[`CHP_OUT_MUTE];
         dac_right_mute <= reconfig_permit_reg | settling | rout_reg[`CHP_OUT_MUTE];
         adc_mute <= settling;
      end
   end
endmodule // chp_host_port
`default_nettype wire

/* File: test/chp_host_port_props.sv */
/*
 Assertions on the pins of chp_host_port.
 Assumes a bind to each instance and the design's INIT_CYCLES.
*/
`timescale 1ns/1ps
`default_nettype none
module chp_host_port_props #(
   parameter [15:0] INIT_CYCLES = 16'd4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic sys_rst,
   // Host bus
   input wire logic [1:0] direct_select,
   input wire logic host_rd,
   input wire logic host_wr,
   input wire logic [7:0] host_dout,
   input wire logic host_dout_oe,
   // DMA and converters
   input wire logic playback_dma_ack,
   input wire logic capture_dma_ack,
   input wire logic playback_dma_req,
   input wire logic capture_dma_req,
   input wire logic irq_out,
   input wire logic dac_left_mute,
   input wire logic dac_right_mute,
   input wire logic adc_mute
);
   // Fastest ratio is 384; the first sample may be short
   localparam int SETTLE_MIN = 48768;
   logic [15:0] init_cnt_reg;
   logic [19:0] mute_cnt_reg;
   logic mute_prev_reg;
   logic armed_reg;
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         init_cnt_reg <= 16'h0000;
         mute_cnt_reg <= 20'h00000;
         mute_prev_reg <= 1'b1;
         armed_reg <= 1'b0;
      end else begin
         if (init_cnt_reg != 16'hffff) begin
            init_cnt_reg <= init_cnt_reg + 16'h0001;
         end
         mute_cnt_reg <= adc_mute ? mute_cnt_reg + 20'h00001 : 20'h00000;
         mute_prev_reg <= adc_mute;
         // Mute straight out of reset is not a settle interval
         if (adc_mute && !mute_prev_reg) begin
            armed_reg <= 1'b1;
         end
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   read_drive_a: assert property (host_rd |=> host_dout_oe)
      else $error("no bus drive after read");
   drive_cause_a: assert property (host_dout_oe |-> $past(host_rd))
      else $error("bus drive without read");
   dout_hold_a: assert property (!host_rd |=> $stable(host_dout))
      else $error("read data moved without read");
   status_clear_a: assert property (host_wr && direct_select == 2'h2 && !playback_dma_ack |-> ##[1:2] !irq_out)
      else $error("interrupt kept after status write");
   init_read_a: assert property (host_rd && !capture_dma_ack && direct_select != 2'h2
      && init_cnt_reg < INIT_CYCLES - 16'd1 |=> host_dout == 8'h80)
      else $error("lockout read not 80");
   mute_pair_a: assert property (adc_mute |-> dac_left_mute && dac_right_mute)
      else $error("dac live during settle");
   settle_len_a: assert property ($fell(adc_mute) && armed_reg |-> mute_cnt_reg >= SETTLE_MIN)
      else $error("settle interval too short");
   playback_dma_req_clear_a: assert property ($fell(playback_dma_req) |->
      $past(host_wr && playback_dma_ack) || $past(host_wr && playback_dma_ack, 2))
      else $error("playback request dropped unserved");
   capture_dma_req_clear_a: assert property ($fell(capture_dma_req) |->
      $past(host_rd && capture_dma_ack) || $past(host_rd && capture_dma_ack, 2))
      else $error("capture request dropped unserved");
endmodule // chp_host_port_props
bind chp_host_port chp_host_port_props #(.INIT_CYCLES(INIT_CYCLES)) u_props (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .direct_select(direct_select), .host_rd(host_rd),
   .host_wr(host_wr), .host_dout(host_dout), .host_dout_oe(host_dout_oe),
   .playback_dma_ack(playback_dma_ack), .capture_dma_ack(capture_dma_ack),
   .playback_dma_req(playback_dma_req), .capture_dma_req(capture_dma_req), .irq_out(irq_out),
   .dac_left_mute(dac_left_mute), .dac_right_mute(dac_right_mute), .adc_mute(adc_mute)
);
`default_nettype wire

/* File: test/chp_host_model.sv */
/*
 Host bus master model: one strobed byte cycle per call.
 Assumes calls come from one process, driving on falling edges.
*/
`timescale 1ns/1ps
`default_nettype none
module chp_host_model (
   // Clock
   input wire logic sys_clk,
   // Host bus
   output logic [1:0] direct_select,
   output logic host_rd,
   output logic host_wr,
   output logic [7:0] host_din,
   // DMA grants
   output logic playback_dma_ack,
   output logic capture_dma_ack
);
   initial begin
      direct_select = 2'h0;
      host_rd = 1'b0;
      host_wr = 1'b0;
      host_din = 8'h00;
      playback_dma_ack = 1'b0;
      capture_dma_ack = 1'b0;
   end
   // Two cycles a call keeps window reads clear of index writes
   task automatic xfer(input logic [1:0] sel, input logic [7:0] data, input logic wr, input logic ack);
      @(negedge sys_clk);
      direct_select = sel;
      host_din = data;
      host_wr = wr;
      host_rd = !wr;
      playback_dma_ack = ack && wr;
      capture_dma_ack = ack && !wr;
      @(negedge sys_clk);
      host_wr = 1'b0;
      host_rd = 1'b0;
      playback_dma_ack = 1'b0;
      capture_dma_ack = 1'b0;
      // Released bus must not look like the last byte
      host_din = ~data;
      direct_select = ~sel;
   endtask
endmodule // chp_host_model
`default_nettype wire

/* File: test/tb_top.sv */
/*
 Self-checking bench for chp_host_port with a host bus model.
 Assumes crystal A ticks every cycle and a short init lockout.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam [15:0] INIT_N = 16'd6;
   logic sys_clk, sys_rst, host_rd, host_wr, host_dout_oe, playback_dma_ack, capture_dma_ack;
   logic playback_dma_req, capture_dma_req, irq_out, xtal_a_tick, xtal_b_tick;
   logic dac_left_mute, dac_right_mute, adc_mute;
   logic [1:0] direct_select;
   logic [7:0] host_din, host_dout, d;
   logic [15:0] adc_left, adc_right, dac_left, dac_right, e;
   logic [15:0] exp_q[$];
   integer failures, checked, cycles, n;
   integer seed = 64;
   chp_host_port #(.INIT_CYCLES(INIT_N)) DUT (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .direct_select(direct_select), .host_rd(host_rd),
      .host_wr(host_wr), .host_din(host_din), .host_dout(host_dout), .host_dout_oe(host_dout_oe),
      .playback_dma_ack(playback_dma_ack), .capture_dma_ack(capture_dma_ack),
      .playback_dma_req(playback_dma_req), .capture_dma_req(capture_dma_req), .irq_out(irq_out),
      .xtal_a_tick(xtal_a_tick), .xtal_b_tick(xtal_b_tick), .adc_left(adc_left), .adc_right(adc_right),
      .dac_left(dac_left), .dac_right(dac_right), .dac_left_mute(dac_left_mute),
      .dac_right_mute(dac_right_mute), .adc_mute(adc_mute)
   );
   chp_host_model host (
      .sys_clk(sys_clk), .direct_select(direct_select), .host_rd(host_rd), .host_wr(host_wr),
      .host_din(host_din), .playback_dma_ack(playback_dma_ack), .capture_dma_ack(capture_dma_ack)
   );
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      checked = checked + 1;
      if (seen !== want) begin
         failures = failures + 1;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done;
      if (failures == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic rd(input logic [1:0] sel, input logic [7:0] mask, input logic [7:0] want);
      exp_q.push_back({mask, want & mask});
      host.xfer(sel, 8'h00, 1'b0, 1'b0);
   endtask
   task automatic wr(input logic [1:0] sel, input logic [7:0] data);
      host.xfer(sel, data, 1'b1, 1'b0);
   endtask
   task automatic wait_on(input integer which, input logic v, input integer lim);
      integer k;
      k = 0;
      while ((which == 0 ? irq_out : which == 1 ? adc_mute : playback_dma_req) !== v && k < lim) begin
         @(negedge sys_clk);
         k = k + 1;
      end
   endtask
   // Read data stands one cycle with its drive enable
   always @(negedge sys_clk) begin
      if (host_dout_oe === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         check(host_dout & e[15:8], e[7:0]);
      end
   end
   always @(negedge sys_clk) begin
      adc_left <= 16'($random(seed));
      adc_right <= 16'($random(seed));
      xtal_b_tick <= ~xtal_b_tick;
   end
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles == 90000) begin
         failures = failures + 1;
         test_done();
      end
   end
   initial begin
      sys_rst = 1'b1;
      xtal_a_tick = 1'b1;
      xtal_b_tick = 1'b0;
      adc_left = 16'h0000;
      adc_right = 16'h0000;
      failures = 0;
      checked = 0;
      cycles = 0;
      repeat (5) @(negedge sys_clk);
      sys_rst = 1'b0;
      rd(2'h0, 8'hff, 8'h80);
      rd(2'h1, 8'hff, 8'h80);
      repeat (INIT_N) @(negedge sys_clk);
      rd(2'h0, 8'hff, 8'h40);
      wr(2'h0, 8'h5f);
      rd(2'h0, 8'hff, 8'h4f);
      check({7'h00, dac_left_mute & dac_right_mute}, 8'h01);
      for (n = 0; n < 16; n = n + 1) begin
         if (n != 11 && n != 12) begin
            d = (n == 8) ? 8'h5a : (n == 9) ? 8'h00 : 8'($random(seed));
            wr(2'h0, 8'h40 | n[7:0]);
            wr(2'h1, d);
            rd(2'h1, 8'hff, d);
         end
      end
      wr(2'h0, 8'h4c);
      rd(2'h1, 8'hff, 8'h05);
      wr(2'h0, 8'h08);
      wr(2'h1, 8'h00);
      rd(2'h1, 8'hff, 8'h5a);
      wr(2'h0, 8'h09);
      wr(2'h1, 8'hfe);
      rd(2'h1, 8'hff, 8'h02);
      wr(2'h0, 8'h0b);
      rd(2'h1, 8'h20, 8'h20);
      check({7'h00, adc_mute}, 8'h01);
      wait_on(1, 1'b0, 60000);
      check({7'h00, adc_mute}, 8'h00);
      rd(2'h1, 8'h20, 8'h00);
      wr(2'h0, 8'h0e);
      wr(2'h1, 8'h00);
      wr(2'h0, 8'h0f);
      wr(2'h1, 8'h02);
      wr(2'h0, 8'h0a);
      wr(2'h1, 8'h02);
      wr(2'h0, 8'h09);
      wr(2'h1, 8'h03);
      wr(2'h2, 8'h00);
      wait_on(0, 1'b1, 3000);
      check({7'h00, irq_out}, 8'h01);
      rd(2'h2, 8'h01, 8'h01);
      d = 8'($random(seed));
      wr(2'h2, d);
      rd(2'h2, 8'h01, 8'h00);
      check({7'h00, irq_out}, 8'h00);
      wr(2'h0, 8'h29);
      wait_on(0, 1'b1, 3000);
      rd(2'h2, 8'h0e, 8'h06);
      // Serve what was pending before the hold bites
      for (n = 0; n < 4; n = n + 1) begin
         host.xfer(2'h3, 8'h00, 1'b0, 1'b1);
         d = 8'($random(seed));
         host.xfer(2'h3, d, 1'b1, 1'b1);
         // Status read after a write, never straight after an unqueued capture read
         d = (n == 0) ? 8'h0e : (n == 1) ? 8'h02 : (n == 2) ? 8'h0a : 8'h00;
         rd(2'h2, (n == 3) ? 8'h02 : 8'h0e, d);
      end
      // Over two and a half sample periods at the chosen rate
      repeat (1000) @(negedge sys_clk);
      check({7'h00, playback_dma_req | capture_dma_req}, 8'h00);
      check(dac_left[7:0] | dac_left[15:8] | dac_right[7:0] | dac_right[15:8], 8'h00);
      wr(2'h2, 8'h00);
      wait_on(2, 1'b1, 2000);
      check({7'h00, playback_dma_req}, 8'h01);
      test_done();
   end
endmodule // tb_top
`default_nettype wire
